// [lpm_consts.svh]
// constants of the low power mode control block: offsets, codes, masks, resets, counts
// assumes a 32-bit APB slave with byte addresses 8'h00 to 8'hFC
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
`define OFS_WRITE_ENABLE   8'h00
`define OFS_POWER_MODE     8'h04
`define OFS_SLEEP_CLOCK    8'h08
`define OFS_OSC_WAIT       8'h0C
`define OFS_STOP_B         8'h10
`define OFS_STOP_C         8'h14
`define OFS_STOP_D         8'h18
`define OFS_SUBCLK_WAIT    8'h1C
`define OFS_PLL_WAIT       8'h20
`define OFS_DSTBY_CTRL     8'h24
`define OFS_IRQ_STATUS     8'h28
`define OFS_IRQ_MASK       8'h2C
`define OFS_DIRQ_EN        6'h0C
`define OFS_DIRQ_FLAG      6'h10
`define OFS_DIRQ_EDGE      6'h14
`define MODE_HIGH          3'h0
`define MODE_MIDDLE        3'h2
`define MODE_LOW1          3'h6
`define MODE_LOW2          3'h7
`define RCLK_LOW_OSC       3'h0
`define RCLK_HIGH_OSC      3'h1
`define RCLK_MAIN_OSC      3'h2
`define FLAG_BIT           7
`define WEN_BIT            0
`define DSLP_BIT           31
`define STOPC_CLK_ACC      19
`define STOPC_IR           20
`define STOPC_MASK_A       32'h0018_0000
`define STOPC_MASK_B       32'h0347_0002
`define IRQ_MODE_DONE      0
`define IRQ_OSC_STABLE     1
`define IRQ_DSTBY_WAKE     2
`define RST_POWER_MODE     3'h0
`define RST_SLEEP_CLOCK    3'h1
`define RST_OSC_WAIT       5'h00
`define WAIT_MAX_A         5'h07
`define WAIT_MAX_B         5'h0F
`define WAIT_SHORT         20'h00002
`define WAIT_B_512         20'h00200
`define WAIT_LONG          20'h00400
`define WAIT_B_16K         20'h04000
`define MODE_TRANS_CYCLES  8'h10
`endif

// [lpm_pkg.sv]
// types shared by the low power mode control block
// assumes the constants header is included by the design file
package lpm_pkg;
    typedef enum logic [1:0] {
        TR_IDLE = 2'b01,
        TR_BUSY = 2'b10
    } trans_state_t;
endpackage : lpm_pkg

// [low_power_mode_control.sv]
// low power mode control: power mode, sleep return clock, oscillator wait, module stop, deep standby regs
// assumes APB3 master on pclk, peripherals that honour the clock enables, synchronous inputs
//
// Decided for this implementation: the address map and the APB register port.
`include "lpm_consts.svh"

module low_power_mode_control #(
    parameter bit         VARIANT_B         = 1'b0,
    parameter int         WAIT_SHIFT        = 0,
    parameter logic [7:0] MODE_TRANS_CYCLES = `MODE_TRANS_CYCLES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // power mode and clock selection
    output logic      [2:0]  power_mode_select,
    output logic             mode_transition_flag,
    output logic      [2:0]  sleep_return_clock_sel,
    output logic             deep_sleep_enable,
    // oscillator stabilisation
    input  wire logic        osc_start,
    output logic             osc_stable,
    // module clock enables
    output logic      [31:0] clk_en_b,
    output logic      [31:0] clk_en_c,
    output logic      [31:0] clk_en_d,
    // deep standby wake sources
    input  wire logic [31:0] dstby_wake,
    // interrupt
    output logic             irq
);

    localparam logic [31:0] STOPC_MASK = VARIANT_B ? `STOPC_MASK_B : `STOPC_MASK_A;

    logic                    wen;
    logic [4:0]              osc_wait_select;
    logic [19:0]             osc_cnt;
    logic [7:0]              trans_cnt;
    lpm_pkg::trans_state_t   tstate;
    logic [7:0]              subclk_wait;
    logic [7:0]              pll_wait;
    logic [7:0]              dstby_ctrl;
    logic [2:0]              irq_status;
    logic [2:0]              irq_mask;
    logic [31:0]             dirq_en;
    logic [31:0]             dirq_flag;
    logic [31:0]             dirq_edge;
    logic [31:0]             wake_prev;
    logic [31:0]             bkp [32];
    logic [31:0]             rd_data;
    logic                    bad;
    logic                    setup;
    logic                    wr;
    logic                    pwr;
    logic [31:0]             wake_hit;
    logic [2:0]              irq_set;
    logic [2:0]              next_status;

    function automatic logic mode_ok(input logic [2:0] c);
        if (VARIANT_B)
            return c == `MODE_HIGH || c == `MODE_LOW1 || c == `MODE_LOW2;
        else
            return c == `MODE_HIGH || c == `MODE_MIDDLE;
    endfunction : mode_ok

    function automatic logic clk_ok(input logic [2:0] c);
        if (VARIANT_B)
            return c == `RCLK_HIGH_OSC || c == `RCLK_MAIN_OSC;
        else
            return c == `RCLK_LOW_OSC || c == `RCLK_HIGH_OSC || c == `RCLK_MAIN_OSC;
    endfunction : clk_ok

    function automatic logic wait_ok(input logic [4:0] c);
        return c <= (VARIANT_B ? `WAIT_MAX_B : `WAIT_MAX_A);
    endfunction : wait_ok

    // oscillator cycles for a wait code
    function automatic logic [19:0] wait_cycles(input logic [4:0] c);
        logic [19:0] r;
        r = `WAIT_SHORT;
        if (!VARIANT_B)
        begin
            if (c != 5'h00)
                r = `WAIT_LONG << (c - 5'h01);
        end
        else if (c <= 5'h05)
            r = `WAIT_SHORT << c;
        else if (c == 5'h06)
            r = `WAIT_B_512;
        else if (c <= 5'h09)
            r = `WAIT_LONG << (c - 5'h07);
        else
            r = `WAIT_B_16K << (c - 5'h0A);
        return r;
    endfunction : wait_cycles

    assign setup = psel & ~penable;
    assign wr    = psel & penable & pready & pwrite & ~bad;
    assign pwr   = wr & wen;

    // read mux and address check
    always_comb
    begin
        rd_data = 32'h0000_0000;
        bad     = 1'b0;
        if (paddr[1:0] != 2'h0)
            bad = 1'b1;
        else if (paddr[7])
        begin
            bad     = !VARIANT_B;
            rd_data = VARIANT_B ? bkp[paddr[6:2]] : 32'h0000_0000;
        end
        else if (VARIANT_B && paddr[7:4] inside {4'h3, 4'h4, 4'h5})
        begin
            case (paddr[7:2])
                `OFS_DIRQ_EN, `OFS_DIRQ_EN + 6'h1, `OFS_DIRQ_EN + 6'h2, `OFS_DIRQ_EN + 6'h3:
                    rd_data = {24'h0, dirq_en[8 * paddr[3:2] +: 8]};
                `OFS_DIRQ_FLAG, `OFS_DIRQ_FLAG + 6'h1, `OFS_DIRQ_FLAG + 6'h2, `OFS_DIRQ_FLAG + 6'h3:
                    rd_data = {24'h0, dirq_flag[8 * paddr[3:2] +: 8]};
                `OFS_DIRQ_EDGE, `OFS_DIRQ_EDGE + 6'h1, `OFS_DIRQ_EDGE + 6'h2, `OFS_DIRQ_EDGE + 6'h3:
                    rd_data = {24'h0, dirq_edge[8 * paddr[3:2] +: 8]};
                default:
                    bad = 1'b1;
            endcase
        end
        else
        begin
            case (paddr)
                `OFS_WRITE_ENABLE:
                    rd_data = {31'h0, wen};
                `OFS_POWER_MODE:
                    rd_data = {24'h0, mode_transition_flag, 4'h0, power_mode_select};
                `OFS_SLEEP_CLOCK:
                    rd_data = {29'h0, sleep_return_clock_sel};
                `OFS_OSC_WAIT:
                    rd_data = {27'h0, osc_wait_select};
                `OFS_STOP_B:
                    rd_data = ~clk_en_b;
                `OFS_STOP_C:
                    rd_data = (~clk_en_c & STOPC_MASK) | {!VARIANT_B & deep_sleep_enable, 31'h0};
                `OFS_STOP_D:
                begin
                    bad     = VARIANT_B;
                    rd_data = VARIANT_B ? 32'h0000_0000 : ~clk_en_d;
                end
                `OFS_SUBCLK_WAIT, `OFS_PLL_WAIT, `OFS_DSTBY_CTRL:
                begin
                    bad = !VARIANT_B;
                    if (paddr == `OFS_SUBCLK_WAIT)
                        rd_data = {24'h0, subclk_wait};
                    else if (paddr == `OFS_PLL_WAIT)
                        rd_data = {24'h0, pll_wait};
                    else
                        rd_data = {24'h0, dstby_ctrl};
                end
                `OFS_IRQ_STATUS:
                    rd_data = {29'h0, irq_status};
                `OFS_IRQ_MASK:
                    rd_data = {29'h0, irq_mask};
                default:
                    bad = 1'b1;
            endcase
        end
    end

    // apb answer: pready high in every access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & bad;
            if (setup & ~pwrite)
                prdata <= rd_data;
        end
    end

    // write protection enable, never protected itself
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wen <= 1'b0;
        else if (wr && paddr == `OFS_WRITE_ENABLE)
            wen <= pwdata[`WEN_BIT];
    end

    // power mode and transition sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_mode_select    <= `RST_POWER_MODE;
            mode_transition_flag <= 1'b0;
            trans_cnt            <= 8'h00;
            tstate               <= lpm_pkg::TR_IDLE;
        end
        else
        begin
            case (tstate)
                lpm_pkg::TR_IDLE:
                begin
                    if (pwr && paddr == `OFS_POWER_MODE && mode_ok(pwdata[2:0]))
                    begin
                        power_mode_select    <= pwdata[2:0];
                        mode_transition_flag <= 1'b1;
                        trans_cnt            <= MODE_TRANS_CYCLES;
                        tstate               <= lpm_pkg::TR_BUSY;
                    end
                end
                lpm_pkg::TR_BUSY:
                begin
                    trans_cnt <= trans_cnt - 8'h01;
                    if (trans_cnt <= 8'h01)
                    begin
                        mode_transition_flag <= 1'b0;
                        tstate               <= lpm_pkg::TR_IDLE;
                    end
                end
                default:
                begin
                    mode_transition_flag <= 1'b0;
                    tstate               <= lpm_pkg::TR_IDLE;
                end
            endcase
        end
    end

    // sleep return clock and oscillator wait selection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_return_clock_sel <= `RST_SLEEP_CLOCK;
            osc_wait_select        <= `RST_OSC_WAIT;
        end
        else
        begin
            if (pwr && paddr == `OFS_SLEEP_CLOCK && clk_ok(pwdata[2:0]))
                sleep_return_clock_sel <= pwdata[2:0];
            if (pwr && paddr == `OFS_OSC_WAIT && wait_ok(pwdata[4:0]))
                osc_wait_select <= pwdata[4:0];
        end
    end

    // main oscillator stabilisation counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_cnt    <= 20'h00000;
            osc_stable <= 1'b0;
        end
        else if (osc_start)
        begin
            osc_stable <= 1'b0;
            osc_cnt    <= ((wait_cycles(osc_wait_select) >> WAIT_SHIFT) == 20'h00000) ? 20'h00001
                        : (wait_cycles(osc_wait_select) >> WAIT_SHIFT);
        end
        else if (osc_cnt != 20'h00000)
        begin
            osc_cnt <= osc_cnt - 20'h00001;
            if (osc_cnt == 20'h00001)
                osc_stable <= 1'b1;
        end
    end

    // module stop registers held as clock enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_en_b          <= 32'h0000_0000;
            clk_en_c          <= 32'h0000_0000;
            clk_en_d          <= 32'h0000_0000;
            deep_sleep_enable <= 1'b0;
        end
        else
        begin
            if (pwr && paddr == `OFS_STOP_B)
                clk_en_b <= ~pwdata;
            if (pwr && paddr == `OFS_STOP_C)
            begin
                clk_en_c          <= ~pwdata & STOPC_MASK;
                deep_sleep_enable <= !VARIANT_B & pwdata[`DSLP_BIT];
            end
            if (pwr && paddr == `OFS_STOP_D && !VARIANT_B)
                clk_en_d <= ~pwdata;
        end
    end

    // variant B wait and deep standby control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            subclk_wait <= 8'h00;
            pll_wait    <= 8'h00;
            dstby_ctrl  <= 8'h00;
        end
        else if (pwr && VARIANT_B)
        begin
            if (paddr == `OFS_SUBCLK_WAIT)
                subclk_wait <= pwdata[7:0];
            if (paddr == `OFS_PLL_WAIT)
                pll_wait <= pwdata[7:0];
            if (paddr == `OFS_DSTBY_CTRL)
                dstby_ctrl <= pwdata[7:0];
        end
    end

    // deep standby wake detection: edge register 1 selects rising
    assign wake_hit = VARIANT_B ? dirq_en & ((dstby_wake & ~wake_prev & dirq_edge)
                    | (~dstby_wake & wake_prev & ~dirq_edge)) : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_prev <= 32'h0000_0000;
        else
            wake_prev <= dstby_wake;
    end

    // deep standby enable, flag and edge registers; a set beats a clear
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_dirq
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    dirq_en[8 * i +: 8]   <= 8'h00;
                    dirq_edge[8 * i +: 8] <= 8'h00;
                    dirq_flag[8 * i +: 8] <= 8'h00;
                end
                else
                begin
                    if (pwr && paddr == {`OFS_DIRQ_EN + 6'(i), 2'h0})
                        dirq_en[8 * i +: 8] <= pwdata[7:0];
                    if (pwr && paddr == {`OFS_DIRQ_EDGE + 6'(i), 2'h0})
                        dirq_edge[8 * i +: 8] <= pwdata[7:0];
                    if (pwr && paddr == {`OFS_DIRQ_FLAG + 6'(i), 2'h0})
                        dirq_flag[8 * i +: 8] <= (dirq_flag[8 * i +: 8] & ~pwdata[7:0])
                                               | wake_hit[8 * i +: 8];
                    else
                        dirq_flag[8 * i +: 8] <= dirq_flag[8 * i +: 8] | wake_hit[8 * i +: 8];
                end
            end
        end
    endgenerate

    // backup registers, not protected and not reset-cleared by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int j = 0; j < 32; j++)
                bkp[j] <= 32'h0000_0000;
        end
        else if (wr && paddr[7] && VARIANT_B)
            bkp[paddr[6:2]] <= pwdata;
    end

    // interrupt status: sticky, write one to clear, set wins
    always_comb
    begin
        irq_set = 3'h0;
        irq_set[`IRQ_MODE_DONE]  = tstate == lpm_pkg::TR_BUSY && trans_cnt <= 8'h01;
        irq_set[`IRQ_OSC_STABLE] = osc_cnt == 20'h00001 && !osc_start;
        irq_set[`IRQ_DSTBY_WAKE] = |wake_hit;
        next_status = irq_status | irq_set;
        if (wr && paddr == `OFS_IRQ_STATUS)
            next_status = (irq_status & ~pwdata[2:0]) | irq_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= 3'h0;
            irq_mask   <= 3'h0;
            irq        <= 1'b0;
        end
        else
        begin
            irq_status <= next_status;
            if (wr && paddr == `OFS_IRQ_MASK)
                irq_mask <= pwdata[2:0];
            irq <= |(next_status & ((wr && paddr == `OFS_IRQ_MASK) ? pwdata[2:0] : irq_mask));
        end
    end

endmodule : low_power_mode_control

// [lpm_checker.sv]
// assertions on the ports of the low power mode control block
// assumes binding to every instance, one clock domain with async active-low reset
module lpm_checker #(
    parameter bit         VARIANT_B         = 1'b0,
    parameter logic [7:0] MODE_TRANS_CYCLES = 8'h10
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave side
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // block outputs and far-side inputs
    input  wire logic [2:0]  power_mode_select,
    input  wire logic        mode_transition_flag,
    input  wire logic [2:0]  sleep_return_clock_sel,
    input  wire logic        deep_sleep_enable,
    input  wire logic        osc_start,
    input  wire logic        osc_stable,
    input  wire logic [31:0] clk_en_b
);
    logic [7:0] flag_cnt;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // cycles the transition flag has been high so far
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_cnt <= 8'h00;
        else
            flag_cnt <= mode_transition_flag ? flag_cnt + 8'h01 : 8'h00;
    end

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        pready ##1 !pready;
    endsequence

    chk_ready_setup: assert property (setup_s |=> access_s)
        else $error("pready not a single cycle after setup");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    chk_mode_codes: assert property (VARIANT_B ? power_mode_select inside {3'h0, 3'h6, 3'h7}
                                               : power_mode_select inside {3'h0, 3'h2})
        else $error("power mode holds an unlisted code");
    chk_sleep_codes: assert property (sleep_return_clock_sel inside {3'h1, 3'h2}
                                      || (!VARIANT_B && sleep_return_clock_sel == 3'h0))
        else $error("sleep return clock holds an unlisted code");
    chk_mode_flag: assert property ($changed(power_mode_select) |-> mode_transition_flag)
        else $error("mode changed without transition flag");
    chk_flag_length: assert property ($fell(mode_transition_flag) |-> flag_cnt == MODE_TRANS_CYCLES)
        else $error("transition flag length wrong");
    chk_mode_frozen: assert property (mode_transition_flag |=> $stable(power_mode_select))
        else $error("mode changed during transition");
    chk_clk_en_write: assert property ($changed(clk_en_b) |-> $past(psel && penable && pwrite)
                                       && $past(paddr) == 8'h10 && clk_en_b == ~$past(pwdata))
        else $error("clock enable b not the inverse of a stop write");
    chk_dsleep_b: assert property (VARIANT_B |-> !deep_sleep_enable)
        else $error("deep sleep enable set in variant b");
    chk_osc_restart: assert property (osc_start |=> !osc_stable)
        else $error("osc stable not cleared by start");
endmodule : lpm_checker

bind low_power_mode_control lpm_checker #(
    .VARIANT_B        (VARIANT_B),
    .MODE_TRANS_CYCLES(MODE_TRANS_CYCLES)
) lpm_checker_i (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .power_mode_select     (power_mode_select),
    .mode_transition_flag  (mode_transition_flag),
    .sleep_return_clock_sel(sleep_return_clock_sel),
    .deep_sleep_enable     (deep_sleep_enable),
    .osc_start             (osc_start),
    .osc_stable            (osc_stable),
    .clk_en_b              (clk_en_b)
);

// [clock_source_model.sv]
// model of the oscillator and wake sources beside the block
// assumes tasks are called from the pclk domain of the bench
module clock_source_model (
    // clock
    input  wire logic        pclk,
    // toward the block
    output logic             osc_start,
    output logic      [31:0] dstby_wake
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        osc_start  = 1'b0;
        dstby_wake = 32'h0000_0000;
    end

    // one-cycle start request, as an oscillator enable gives
    task automatic start_osc();
        @(posedge pclk);
        osc_start <= 1'b1;
        @(posedge pclk);
        osc_start <= 1'b0;
    endtask : start_osc

    task automatic set_wake(input logic [31:0] v);
        @(posedge pclk);
        dstby_wake <= v;
    endtask : set_wake
endmodule : clock_source_model

// [low_power_mode_control_tb.sv]
// testbench: variants a and b side by side on one apb bus
// assumes the clock source model and the bound checker
module low_power_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MTC = 8'h04;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] ea; logic [31:0] eb;} row_t;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata [2];
    logic        pready [2];
    logic        pslverr [2];
    logic [2:0]  mode [2];
    logic        flag [2];
    logic [2:0]  rsel [2];
    logic        dsl [2];
    logic        stab [2];
    logic [31:0] cen_b [2];
    logic        irq [2];
    logic        osc_start;
    logic [31:0] wake;
    logic [31:0] rd [2];
    logic        er [2];
    int          failures;
    int          tests_run;
    int          cycles;
    int          na;
    int          nb;
    int          n;

    // write a code, then read it back on both variants
    row_t rows [13] = '{
        '{8'h04, 32'h2, 32'h2, 32'h0},
        '{8'h04, 32'h6, 32'h2, 32'h6},
        '{8'h04, 32'h7, 32'h2, 32'h7},
        '{8'h04, 32'h0, 32'h0, 32'h0},
        '{8'h08, 32'h0, 32'h0, 32'h1},
        '{8'h08, 32'h2, 32'h2, 32'h2},
        '{8'h08, 32'h1, 32'h1, 32'h1},
        '{8'h14, 32'hFFFF_FFFF, 32'h8018_0000, 32'h0347_0002},
        '{8'h18, 32'hA5, 32'hA5, 32'h0},
        '{8'h30, 32'h5A, 32'h0, 32'h5A},
        '{8'h9C, 32'h1234_5678, 32'h0, 32'h1234_5678},
        '{8'h20, 32'h3, 32'h0, 32'h3},
        '{8'h10, 32'hF00F, 32'hF00F, 32'hF00F}
    };
    // oscillator code and expected stable delay of each variant, shift 8
    row_t oscs [5] = '{
        '{8'h0C, 32'h0, 32'd1, 32'd1},
        '{8'h0C, 32'h1, 32'd4, 32'd1},
        '{8'h0C, 32'h6, 32'd128, 32'd2},
        '{8'h0C, 32'h7, 32'd256, 32'd4},
        '{8'h0C, 32'hF, 32'd256, 32'd2048}
    };

    for (genvar v = 0; v < 2; v++)
    begin : g_var
        low_power_mode_control #(
            .VARIANT_B        (v == 1),
            .WAIT_SHIFT       (8),
            .MODE_TRANS_CYCLES(MTC)
        ) low_power_mode_control_i (
            .pclk                  (pclk),
            .presetn               (presetn),
            .psel                  (psel),
            .penable               (penable),
            .pwrite                (pwrite),
            .paddr                 (paddr),
            .pwdata                (pwdata),
            .prdata                (prdata[v]),
            .pready                (pready[v]),
            .pslverr               (pslverr[v]),
            .power_mode_select     (mode[v]),
            .mode_transition_flag  (flag[v]),
            .sleep_return_clock_sel(rsel[v]),
            .deep_sleep_enable     (dsl[v]),
            .osc_start             (osc_start),
            .osc_stable            (stab[v]),
            .clk_en_b              (cen_b[v]),
            .clk_en_c              (),
            .clk_en_d              (),
            .dstby_wake            (wake),
            .irq                   (irq[v])
        );
    end

    clock_source_model clock_source_model_i (
        .pclk      (pclk),
        .osc_start (osc_start),
        .dstby_wake(wake)
    );

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        #1;
        while (pready[0] !== 1'b1)
        begin
            @(posedge pclk);
            #1;
        end
        rd[0]   = prdata[0];
        rd[1]   = prdata[1];
        er[0]   = pslverr[0];
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        for (int v = 0; v < 2; v++)
        begin
            chk("mode", 32'h0, {29'h0, mode[v]});
            chk("rsel", 32'h1, {29'h0, rsel[v]});
            chk("clk_en_b", 32'h0, cen_b[v]);
        end
    endtask : do_reset

    task automatic print_verdict();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            print_verdict();
        end
    end

    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        do_reset();
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk("locked mode", 32'h0, rd[0]);
        chk("locked stop", 32'h0, cen_b[0]);
        apb(1'b1, 8'h00, 32'h1);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].d);
            repeat (MTC + 2) @(posedge pclk);
            apb(1'b0, rows[i].a, 32'h0);
            chk("row a", rows[i].ea, rd[0]);
            chk("row b", rows[i].eb, rd[1]);
        end
        chk("deep sleep a", 32'h1, {31'h0, dsl[0]});
        chk("deep sleep b", 32'h0, {31'h0, dsl[1]});
        apb(1'b1, 8'h10, 32'hFF);
        #1;
        chk("clk_en_b", 32'hFFFF_FF00, cen_b[0]);
        apb(1'b1, 8'h04, 32'h2);
        #1;
        chk("flag", 32'h1, {31'h0, flag[0]});
        apb(1'b1, 8'h04, 32'h0);
        repeat (MTC) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        chk("held mode", 32'h2, rd[0]);
        foreach (oscs[i])
        begin
            apb(1'b1, 8'h0C, oscs[i].d);
            clock_source_model_i.start_osc();
            na = 0;
            nb = 0;
            n  = 0;
            while ((na == 0 || nb == 0) && n < 4000)
            begin
                @(posedge pclk);
                #1;
                n++;
                if (na == 0 && stab[0] === 1'b1)
                    na = n;
                if (nb == 0 && stab[1] === 1'b1)
                    nb = n;
            end
            chk("osc wait a", oscs[i].ea, 32'(na));
            chk("osc wait b", oscs[i].eb, 32'(nb));
        end
        apb(1'b0, 8'h28, 32'h0);
        chk("status", 32'h3, rd[0]);
        chk("irq masked", 32'h0, {31'h0, irq[0]});
        apb(1'b1, 8'h2C, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq raised", 32'h1, {31'h0, irq[0]});
        apb(1'b1, 8'h28, 32'h7);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq[0]});
        apb(1'b1, 8'h30, 32'h1);
        apb(1'b1, 8'h50, 32'h1);
        clock_source_model_i.set_wake(32'h1);
        repeat (3) @(posedge pclk);
        apb(1'b0, 8'h40, 32'h0);
        chk("wake flag", 32'h1, rd[1]);
        apb(1'b0, 8'h28, 32'h0);
        chk("wake status", 32'h4, rd[1]);
        apb(1'b0, 8'h60, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er[0]});
        chk("unmapped data", 32'h0, rd[0]);
        do_reset();
        print_verdict();
    end
endmodule : low_power_mode_control_tb
